// [tone_gen_regs.svh]
// Register map, field positions and timing counts of the cadence tone generator.
// Assumes inclusion by bare name from the design file and the port checker.
`ifndef TONE_GEN_REGS_SVH
`define TONE_GEN_REGS_SVH
`define TG_ADDR_W          5
`define TG_OFS_CONTROL     5'h00
`define TG_OFS_ON_TIME     5'h01
`define TG_OFS_OFF_TIME    5'h02
`define TG_OFS_SLOT1       5'h03
`define TG_OFS_SLOT2       5'h04
`define TG_OFS_SLOT3       5'h05
`define TG_OFS_FREQ1       5'h06
`define TG_OFS_FREQ4       5'h09
`define TG_OFS_GAIN1       5'h0A
`define TG_OFS_GAIN4       5'h0D
`define TG_OFS_OUT1_GAIN   5'h0E
`define TG_OFS_OUT2_GAIN   5'h0F
`define TG_OFS_CLIP_GAIN   5'h10
`define TG_OFS_STATUS      5'h11
`define TG_NUM_CFG         17
`define TG_CTL_ENABLE      0
`define TG_CTL_GATE_LO     1
`define TG_CTL_DUAL        3
`define TG_CTL_PAT_LO      4
`define TG_CTL_STOP        6
`define TG_CTL_WAVE        7
`define TG_CTL_RATE2X      8
`define TG_CTL_MASK        16'h01FF
`define TG_W15_MASK        16'h7FFF
`define TG_RESET_VAL       16'h0000
`define TG_CLK_HZ          100000000
`define TG_SAMPLE_HZ       8000
`define TG_SAMPLE_DIV      (`TG_CLK_HZ / `TG_SAMPLE_HZ)
`define TG_CLIP_SHIFT      11
`endif

// [tone_gen_pkg.sv]
// Types shared by the cadence tone generator.
// Assumes nothing beyond a SystemVerilog compiler.
package tone_gen_pkg;
    typedef enum logic [3:0] {
        GATE_IDLE  = 4'b0001,
        GATE_ON    = 4'b0010,
        GATE_OFF   = 4'b0100,
        GATE_DRAIN = 4'b1000
    } gate_state_e;
    typedef logic [15:0] word_t;
    typedef logic [1:0]  slot_t;
endpackage : tone_gen_pkg

// [cadence_tone_generator.sv]
// Four-oscillator cadence tone generator with saturation and two scaled outputs.
// Assumes a same-clock register master: one-cycle strobes, read data the next cycle.
//
// Functional notes
// - Four oscillators, sine or square, each with own frequency and gain.
// - Enabled beat sequencer repeats a one-, two- or three-slot cadence per mode.
// - Each slot lasts its duration; own oscillator, plus oscillator four if dual.
// - Beat disabled: continuous osc1, osc2, either plus osc4, or silence.
// - Gate sequencer alternates beat enable for on-time and off-time.
// - Automatic stop finishes the cadence at its last slot; otherwise immediate.
// - One control bit picks immediate or end-of-cadence stopping.
// - One status bit reports tone generator on or off.
// - Two-bit gate mode configures the on/off gating.
// - Two-bit pattern: F1, F2, F1/F2 alternating, or F1/F2/F3.
// - Waveform bit: 1 selects square, 0 sine.
// - Saturation gain on the sum, clipped at full scale.
// - Two sample outputs, each with its own output gain.
// - Direct speaker bit is MSB of first output; valid with square wave.
// - Rate-double clear: 8 kHz sample rate.
// - Rate-double set: 16 kHz rate; only direct output meaningful.
// - Rate-double halves durations and doubles frequencies.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "tone_gen_regs.svh"

module cadence_tone_generator #(
    parameter int unsigned SAMPLE_DIV = `TG_SAMPLE_DIV
) (
    input  wire logic                      clk_sys,
    input  wire logic                      arst_n,
    input  wire logic [`TG_ADDR_W-1:0]     reg_addr,
    input  wire tone_gen_pkg::word_t       reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output tone_gen_pkg::word_t            reg_rdata,
    output tone_gen_pkg::word_t            sample1,
    output tone_gen_pkg::word_t            sample2,
    output logic                           sample_valid,
    output logic                           spk_direct,
    output logic                           tone_active_flag
);
    import tone_gen_pkg::*;

    localparam int unsigned DIV_W = $clog2(SAMPLE_DIV + 1);

    // Slot order for a given pattern: first and last slot index
    function automatic slot_t first_slot(input logic [1:0] pat);
        first_slot = (pat == 2'd1) ? 2'd1 : 2'd0;
    endfunction : first_slot

    function automatic slot_t last_slot(input logic [1:0] pat);
        case (pat)
            2'd0:    last_slot = 2'd0;
            2'd1:    last_slot = 2'd1;
            2'd2:    last_slot = 2'd1;
            default: last_slot = 2'd2;
        endcase
    endfunction : last_slot

    // Parabolic sine approximation, close enough for call-progress tones
    function automatic logic signed [15:0] wave(input logic [15:0] ph, input logic sq);
        logic [14:0] p;
        logic [29:0] prod;
        logic [15:0] mag;
        p    = ph[14:0];
        prod = p * (15'h7FFF - p);
        mag  = sq ? 16'h7FFF : {1'b0, prod[27:13]};
        wave = ph[15] ? -$signed(mag) : $signed(mag);
    endfunction : wave

    // Q15 gain, gain register is unsigned below unity
    function automatic logic signed [15:0] gain15(input logic signed [15:0] s,
                                                  input logic [14:0] g);
        logic signed [31:0] m;
        m = s * $signed({1'b0, g});
        gain15 = m[30:15];
    endfunction : gain15

    word_t               cfg_q [`TG_NUM_CFG];
    word_t               rdata_q;
    logic [DIV_W-1:0]    div_q;
    logic                tick_q;
    logic [15:0]         phase_q [4];
    gate_state_e         state_q;
    gate_state_e         state_d;
    slot_t               slot_q;
    logic [15:0]         slot_cnt_q;
    logic [19:0]         gate_cnt_q;
    logic                active_q;
    word_t               s1_q;
    word_t               s2_q;
    logic                valid_q;
    logic                burst_done_q;

    // Control field decode
    wire word_t       ctl       = cfg_q[`TG_OFS_CONTROL];
    wire logic        enable    = ctl[`TG_CTL_ENABLE];
    wire logic [1:0]  gate_seq_mode = ctl[`TG_CTL_GATE_LO +: 2];
    wire logic        dual_tone_enable = ctl[`TG_CTL_DUAL];
    wire logic [1:0]  cadence_pattern_mode = ctl[`TG_CTL_PAT_LO +: 2];
    wire logic        stop_behaviour = ctl[`TG_CTL_STOP];
    wire logic        waveform_select = ctl[`TG_CTL_WAVE];
    wire logic        rate_double = ctl[`TG_CTL_RATE2X];

    wire logic        beat_on   = gate_seq_mode != 2'd0;
    wire logic        gating    = gate_seq_mode[1];
    wire slot_t       slot_first = first_slot(cadence_pattern_mode);
    wire slot_t       slot_last  = last_slot(cadence_pattern_mode);
    wire logic        running   = (state_q == GATE_ON) || (state_q == GATE_DRAIN);
    wire logic        slot_done = running && beat_on && (slot_cnt_q <= 16'd1);
    wire logic        cad_end   = slot_done && (slot_q == slot_last);
    wire slot_t       slot_next = (slot_q == slot_last) ? slot_first : slot_q + 2'd1;
    wire logic [19:0] on_len    = {7'd0, cfg_q[`TG_OFS_ON_TIME][12:0]}
                                  << cfg_q[`TG_OFS_ON_TIME][15:13];
    wire logic [19:0] off_len   = {7'd0, cfg_q[`TG_OFS_OFF_TIME][12:0]}
                                  << cfg_q[`TG_OFS_OFF_TIME][15:13];
    wire logic        gate_done = gate_cnt_q <= 20'd1;

    // Halving the divider doubles the sample rate, so counts and steps scale with it
    wire logic [DIV_W-1:0] div_top = rate_double ? DIV_W'(SAMPLE_DIV / 2 - 1)
                                                 : DIV_W'(SAMPLE_DIV - 1);

    function automatic word_t slot_len(input slot_t s);
        slot_len = cfg_q[`TG_OFS_SLOT1 + 5'(s)];
    endfunction : slot_len

    // Register write path and read mux
    wire logic        addr_cfg  = reg_addr < 5'(`TG_NUM_CFG);
    wire word_t       wr_mask   = (reg_addr == `TG_OFS_CONTROL) ? `TG_CTL_MASK
                                  : (reg_addr <= `TG_OFS_SLOT3) ? 16'hFFFF : `TG_W15_MASK;
    wire word_t       status    = {12'h000, state_q == GATE_ON, slot_q, active_q};
    wire word_t       rd_mux    = addr_cfg ? cfg_q[reg_addr]
                                  : (reg_addr == `TG_OFS_STATUS) ? status : 16'h0000;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `TG_NUM_CFG; i++) cfg_q[i] <= `TG_RESET_VAL;
        end else if (reg_wr && addr_cfg) begin
            cfg_q[reg_addr] <= reg_wdata & wr_mask;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) rdata_q <= 16'h0000;
        else         rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end

    // Sample tick divider
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= div_q >= div_top;
            div_q  <= (div_q >= div_top) ? '0 : div_q + 1'b1;
        end
    end

    // Free-running phase accumulators
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) phase_q[i] <= 16'h0000;
        end else if (tick_q) begin
            for (int i = 0; i < 4; i++)
                phase_q[i] <= phase_q[i] + {1'b0, cfg_q[`TG_OFS_FREQ1 + 5'(i)][14:0]};
        end
    end

    // Gate sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            GATE_IDLE: begin
                // A finished single burst waits for a fresh control write
                if (enable && !burst_done_q) state_d = GATE_ON;
            end
            GATE_ON: begin
                if (!enable || (gating && gate_done)) begin
                    // Auto stop only matters while a cadence is running
                    if (stop_behaviour && beat_on) state_d = GATE_DRAIN;
                    else if (enable)               state_d = GATE_OFF;
                    else                           state_d = GATE_IDLE;
                end
            end
            GATE_DRAIN: begin
                if (cad_end) state_d = (enable && gating) ? GATE_OFF : GATE_IDLE;
            end
            GATE_OFF: begin
                if (!enable)        state_d = GATE_IDLE;
                else if (gate_done) state_d = (gate_seq_mode == 2'd3) ? GATE_IDLE
                                                                      : GATE_ON;
            end
            default: state_d = GATE_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q    <= GATE_IDLE;
            gate_cnt_q <= 20'd0;
        end else if (tick_q) begin
            state_q <= state_d;
            if (state_d == GATE_ON && state_q != GATE_ON)        gate_cnt_q <= on_len;
            else if (state_d == GATE_OFF && state_q != GATE_OFF) gate_cnt_q <= off_len;
            else if (gate_cnt_q != 20'd0)                        gate_cnt_q <= gate_cnt_q - 20'd1;
        end
    end

    // Single-burst mode remembers that its burst has run out
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            burst_done_q <= 1'b0;
        end else if (reg_wr && reg_addr == `TG_OFS_CONTROL) begin
            burst_done_q <= 1'b0;
        end else if (tick_q && enable && state_q == GATE_OFF && state_d == GATE_IDLE) begin
            burst_done_q <= 1'b1;
        end
    end

    // Beat sequencer: slot index and slot duration count
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slot_q     <= 2'd0;
            slot_cnt_q <= 16'd0;
        end else if (tick_q) begin
            if (!running || state_d == GATE_OFF || state_d == GATE_IDLE) begin
                slot_q     <= slot_first;
                slot_cnt_q <= slot_len(slot_first);
            end else if (slot_done) begin
                slot_q     <= slot_next;
                slot_cnt_q <= slot_len(slot_next);
            end else begin
                slot_cnt_q <= slot_cnt_q - 16'd1;
            end
        end
    end

    // Tone mixing
    wire logic signed [15:0] osc [4];
    for (genvar g = 0; g < 4; g++) begin : g_osc
        assign osc[g] = gain15(wave(phase_q[g], waveform_select),
                               cfg_q[`TG_OFS_GAIN1 + 5'(g)][14:0]);
    end

    wire slot_t              main_sel = beat_on ? slot_q
                                        : {1'b0, cadence_pattern_mode == 2'd1};
    wire logic signed [16:0] mix_sum  = 17'(osc[main_sel])
                                        + (dual_tone_enable ? 17'(osc[3]) : 17'sd0);
    wire logic signed [16:0] mix      = (state_q == GATE_ON || state_q == GATE_DRAIN)
                                        ? mix_sum : 17'sd0;
    wire logic signed [33:0] sat_prod = mix * $signed({2'b00, cfg_q[`TG_OFS_CLIP_GAIN][14:0]});
    wire logic signed [22:0] sat_full = sat_prod[33:11];
    // Hard clip on purpose: the cut-off peaks add harmonics
    wire logic signed [15:0] sat      = (sat_full > 23'sd32767)  ? 16'sh7FFF
                                      : (sat_full < -23'sd32768) ? 16'sh8000
                                      : sat_full[15:0];
    wire logic signed [15:0] out1     = gain15(sat, cfg_q[`TG_OFS_OUT1_GAIN][14:0]);
    wire logic signed [15:0] out2     = gain15(sat, cfg_q[`TG_OFS_OUT2_GAIN][14:0]);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_q     <= 16'h0000;
            s2_q     <= 16'h0000;
            valid_q  <= 1'b0;
            active_q <= 1'b0;
        end else begin
            valid_q <= tick_q;
            if (tick_q) begin
                s1_q     <= out1;
                s2_q     <= out2;
                active_q <= state_q != GATE_IDLE;
            end
        end
    end

    assign reg_rdata        = rdata_q;
    assign sample1          = s1_q;
    assign sample2          = s2_q;
    // At 16 kHz the word outputs run faster than their consumers; the bit still works
    assign sample_valid     = valid_q;
    assign spk_direct       = s1_q[15];
    assign tone_active_flag = active_q;

endmodule : cadence_tone_generator

// [tone_gen_sva.sv]
// Port checker for the tone generator: register bus, sample stream, status.
// Assumes one clock domain and the register map header of the design.
`timescale 1ns/1ps
`include "tone_gen_regs.svh"
module tone_gen_sva #(
    parameter int unsigned SAMPLE_DIV = 8
) (
    input wire logic                  clk_sys,
    input wire logic                  arst_n,
    input wire logic [`TG_ADDR_W-1:0] reg_addr,
    input wire tone_gen_pkg::word_t   reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire tone_gen_pkg::word_t   reg_rdata,
    input wire tone_gen_pkg::word_t   sample1,
    input wire tone_gen_pkg::word_t   sample2,
    input wire logic                  sample_valid,
    input wire logic                  spk_direct,
    input wire logic                  tone_active_flag
);
    import tone_gen_pkg::*;
    logic        rate_q;
    logic        stale_q;
    logic [15:0] gap_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // A control write may restart the divider, so the next gap is not judged
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rate_q  <= 1'b0;
            stale_q <= 1'b1;
            gap_q   <= 16'h0000;
        end else begin
            gap_q <= sample_valid ? 16'h0001 : gap_q + 16'h0001;
            if (reg_wr && reg_addr == `TG_OFS_CONTROL) begin
                rate_q  <= reg_wdata[`TG_CTL_RATE2X];
                stale_q <= 1'b1;
            end else if (sample_valid) begin
                stale_q <= 1'b0;
            end
        end
    end
    sequence ctl_write;
        reg_wr && reg_addr == `TG_OFS_CONTROL;
    endsequence
    sequence ctl_read;
        reg_rd && reg_addr == `TG_OFS_CONTROL;
    endsequence
    a_valid_single: assert property (sample_valid |=> !sample_valid)
        else $error("sample strobe longer than one cycle");
    a_tick_period: assert property (sample_valid && !stale_q |->
        gap_q == (rate_q ? SAMPLE_DIV / 2 : SAMPLE_DIV)) else $error("sample period off");
    a_spk_msb: assert property (spk_direct == sample1[15])
        else $error("direct bit differs from output sign");
    a_samples_hold: assert property (
        !sample_valid |-> $stable(sample1) && $stable(sample2))
        else $error("samples moved between strobes");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_status_read: assert property (reg_rd && reg_addr == `TG_OFS_STATUS |=>
        reg_rdata[0] == $past(tone_active_flag)) else $error("status bit differs");
    a_ctl_readback: assert property (ctl_write ##1 ctl_read |=>
        reg_rdata == ($past(reg_wdata, 2) & `TG_CTL_MASK)) else $error("control readback");
    a_idle_silent: assert property (sample_valid && !tone_active_flag |->
        sample1 == 16'h0000 && sample2 == 16'h0000) else $error("sound while idle");
endmodule : tone_gen_sva
bind cadence_tone_generator tone_gen_sva #(.SAMPLE_DIV(SAMPLE_DIV)) sva_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample1(sample1),
    .sample2(sample2), .sample_valid(sample_valid), .spk_direct(spk_direct),
    .tone_active_flag(tone_active_flag));

// [tone_sink.sv]
// Mixer and speaker amplifier model: keeps the last sample of each output.
// Assumes samples are only meaningful in the cycle of sample_valid.
`timescale 1ns/1ps
module tone_sink (
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    input  wire tone_gen_pkg::word_t sample1,
    input  wire tone_gen_pkg::word_t sample2,
    input  wire logic                sample_valid,
    output tone_gen_pkg::word_t      heard1,
    output tone_gen_pkg::word_t      heard2
);
    import tone_gen_pkg::*;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            heard1 <= 16'h0000;
            heard2 <= 16'h0000;
        end else if (sample_valid) begin
            heard1 <= sample1;
            heard2 <= sample2;
        end
    end
endmodule : tone_sink

// [cadence_tone_generator_tb.sv]
// Self-checking bench: register access, cadences, gating, stop modes, rates.
// Assumes a short sample divider so a cadence fits in a few hundred cycles.
`timescale 1ns/1ps
module cadence_tone_generator_tb;
    import tone_gen_pkg::*;
    localparam int SD = 8;
    logic       clk_sys = 1'b0;
    logic       arst_n, reg_wr, reg_rd, sample_valid, spk_direct, tone_active_flag;
    logic [4:0] reg_addr;
    word_t      reg_wdata, reg_rdata, sample1, sample2, heard1, heard2, s, v;
    int         seed, bad_count, checks_done, cyc, a, i, last, c0, m;
    int         exp_len[4];
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    cadence_tone_generator #(.SAMPLE_DIV(SD)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sample1(sample1), .sample2(sample2),
        .sample_valid(sample_valid), .spk_direct(spk_direct),
        .tone_active_flag(tone_active_flag));
    tone_sink sink (.clk_sys(clk_sys), .arst_n(arst_n), .sample1(sample1),
        .sample2(sample2), .sample_valid(sample_valid), .heard1(heard1), .heard2(heard2));
    task automatic chk(input string what, input word_t seen, input word_t want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : chk
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [4:0] ad, input word_t d);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [4:0] ad, output word_t d);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic tick;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk_sys);
            #1;
            if (sample_valid === 1'b1) return;
        end
        bad_count++;
        complete_run;
    endtask : tick
    function automatic word_t ctl(int gm, int dual, int pat, int stp, int wave, int rate);
        return 16'(1 | gm << 1 | dual << 3 | pat << 4 | stp << 6 | wave << 7 | rate << 8);
    endfunction : ctl
    // The first run seen is partial, so run lengths are judged from the second change on
    task automatic runs(input int sh, input int msk, input int n);
        int val, prev, len, nt;
        word_t st;
        prev = 0;
        len = 0;
        nt = 0;
        for (int k = 0; k < n; k++) begin
            tick;
            rd(5'h11, st);
            val = int'(st >> sh) & msk;
            if (val == prev && nt > 0) begin
                len++;
            end else begin
                if (nt >= 2) chk("run length", 16'(len), 16'(exp_len[prev]));
                nt++;
                prev = val;
                len = 1;
            end
        end
    endtask : runs
    initial begin
        seed = 92866;
        arst_n = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        for (a = 0; a < 18; a++) begin
            rd(5'(a), s);
            chk("reset value", s, 16'h0000);
        end
        rd(5'h1F, s);
        chk("unmapped", s, 16'h0000);
        wr(5'h11, 16'hFFFF);
        rd(5'h11, s);
        chk("status", s, 16'h0000);
        for (a = 0; a < 17; a++) begin
            v = 16'($random(seed)) & ~16'(a == 0);
            wr(5'(a), v);
            rd(5'(a), s);
            chk("readback", s, v & (a == 0 ? 16'h01FF : a < 6 ? 16'hFFFF : 16'h7FFF));
        end
        for (a = 10; a < 17; a++) wr(5'(a), a == 10 || a == 15 ? 16'h0000 :
            a == 16 ? 16'h0800 : 16'h7FFF);
        for (i = 0; i < 4; i++) begin
            wr(5'h00, ctl(0, i / 2, i % 2, 0, 1, 0));
            repeat (4) tick;
            chk("tone present", 16'(heard1 != 0), 16'(i != 0));
            chk("muted output", heard2, 16'h0000);
        end
        wr(5'h0F, 16'h7FFF);
        repeat (3) tick;
        chk("second output", 16'(heard2 != 0), 16'h0001);
        for (m = 2; m < 4; m++) begin
            for (i = 0; i < 3; i++) begin
                exp_len[i] = 1 + ($random(seed) & 3);
                wr(5'(3 + i), 16'(exp_len[i]));
            end
            wr(5'h00, ctl(1, 0, m, 0, 0, 0));
            runs(1, 3, 30);
            wr(5'h00, 16'h0000);
            repeat (3) tick;
            rd(5'h11, s);
            chk("stopped status", s, 16'h0000);
        end
        for (i = 0; i < 3; i++) wr(5'(3 + i), 16'h0003);
        wr(5'h00, ctl(1, 0, 3, 1, 0, 0));
        tick;
        wr(5'h00, ctl(1, 0, 3, 1, 0, 0) - 16'h0001);
        last = 0;
        for (i = 0; i < 20; i++) begin
            tick;
            rd(5'h11, s);
            if (s[0] === 1'b1 && int'(s[2:1]) > last) last = int'(s[2:1]);
        end
        chk("cadence end slot", 16'(last), 16'h0002);
        m = 2 + ($random(seed) & 3);
        exp_len[1] = 2 * m;
        exp_len[0] = m + 1;
        wr(5'h01, {3'd1, 13'(m)});
        wr(5'h02, {3'd0, 13'(m + 1)});
        wr(5'h00, ctl(2, 0, 0, 0, 0, 0));
        runs(3, 1, 50);
        wr(5'h00, ctl(3, 0, 0, 0, 0, 0));
        repeat (25) tick;
        rd(5'h11, s);
        chk("burst ended", 16'(s[0]), 16'h0000);
        for (i = 1; i >= 0; i--) begin
            wr(5'h00, ctl(0, 0, 0, 0, 1, i));
            repeat (2) tick;
            c0 = cyc;
            tick;
            chk("tick gap", 16'(cyc - c0), 16'(i == 1 ? SD / 2 : SD));
        end
        complete_run;
    end
endmodule : cadence_tone_generator_tb
